// [vslc_ctrl_filter.sv]
// Glitch filter and transition rate limiter for one video control signal.
// Assumes the input is synchronous to clock.
`timescale 1ns/100ps
module vslc_ctrl_filter import vslc_pkg::*; #(
    parameter int MAX_TRANS = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic clock_en,
    input wire logic rst_n,
    // Control
    input wire logic glitch_en,
    input wire logic limit_en,
    // Signal
    input wire logic sig_in,
    output logic sig_out
);
    localparam logic [CTRL_CNT_W-1:0] WIN = CTRL_CNT_W'(CTRL_WIN_CYC);
    localparam logic [1:0] MINP = 2'(CTRL_MIN_PULSE);

    function automatic logic [CTRL_CNT_W-1:0] sat_inc(
        input logic [CTRL_CNT_W-1:0] v);
        return (v >= WIN) ? WIN : v + 1'b1;
    endfunction

    logic cand_ff;
    logic [1:0] run_ff;
    logic out_ff;
    logic [CTRL_CNT_W-1:0] age_ff [MAX_TRANS];

    wire logic qual = glitch_en ? ((run_ff == MINP) ? cand_ff : out_ff)
                                : sig_in;
    // Oldest of the last transitions must have left the window
    wire logic allowed = !limit_en || (age_ff[MAX_TRANS-1] >= WIN);
    wire logic fire = (qual != out_ff) && allowed;

    assign sig_out = out_ff;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cand_ff <= 1'b0;
            run_ff <= 2'h0;
            out_ff <= 1'b0;
            for (int i = 0; i < MAX_TRANS; i++) age_ff[i] <= WIN;
        end else if (clock_en) begin
            cand_ff <= sig_in;
            if (sig_in != cand_ff) run_ff <= 2'h1;
            else if (run_ff != MINP) run_ff <= run_ff + 2'h1;
            if (fire) begin
                out_ff <= qual;
                age_ff[0] <= '0;
                for (int i = 1; i < MAX_TRANS; i++)
                    age_ff[i] <= sat_inc(age_ff[i-1]);
            end else begin
                for (int i = 0; i < MAX_TRANS; i++)
                    age_ff[i] <= sat_inc(age_ff[i]);
            end
        end
    end
endmodule

// [vslc_lane_model.sv]
// Lane standing for the far end: carries every coded word back.
// Assumes one word per enabled clock; rot models a bit slip.
`timescale 1ns/100ps
module vslc_lane_model import vslc_pkg::*; (
    // Clock
    input wire logic clock,
    input wire logic clock_en,
    // Lane control
    input wire logic [OFF_W-1:0] rot,
    input wire logic corrupt,
    // Lane
    input wire logic [WORD_W-1:0] word_in,
    output logic [WORD_W-1:0] word_out
);
    logic [WORD_W-1:0] prev_ff;
    // Newer word sits above the older one, the order the decoder pairs them
    wire [2*WORD_W-1:0] pair = {word_in, prev_ff} << rot;
    wire [WORD_W-1:0] win = pair[2*WORD_W-1:WORD_W];
    // Inverting the whole word always breaks the marker pair
    assign word_out = corrupt ? ~win : win;
    always_ff @(posedge clock) begin
        if (clock_en) begin
            prev_ff <= word_in;
        end
    end
endmodule

// [vslc_link_checker_assertions.sv]
// Port checker for the link coding core.
// Assumes one pixel clock and a synchronous active-low reset.
`timescale 1ns/100ps
module vslc_link_checker import vslc_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic clock_en,
    input wire logic rst_n,
    // Configuration
    input wire logic [1:0] cfg_mode_pin,
    input wire logic [1:0] cfg_mode_reg,
    input wire logic cfg_use_reg,
    input wire logic color_18bit,
    input wire logic [1:0] mode_active,
    // Lane and video
    input wire vslc_pixel_t tx_pixel,
    input wire logic [WORD_W-1:0] tx_word,
    input wire vslc_pixel_t rx_pixel,
    input wire logic rx_word_valid,
    input wire logic rx_word_err,
    input wire logic rx_lock
);
    logic [7:0] code_ff;
    logic [3:0] gap_ff;
    logic [4:0] low_ff;
    wire [1:0] sel_mode = cfg_use_reg ? cfg_mode_reg : cfg_mode_pin;
    wire [PAY_W-1:0] pay = tx_word[PAY_W-1:0];
    wire code_bit = tx_word[POS_INT] ^ (^pay) ^ tx_word[POS_BAL];
    wire [7:0] code_nx = {code_ff[6:0], code_bit};
    wire frame_hit = code_nx[7:4] == CODE_HDR && code_nx[0] == ^code_nx[3:1];
    // The reset word adds one slot, so the gap may reach eight
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            code_ff <= 8'h00;
            gap_ff <= 4'h0;
            low_ff <= 5'h00;
        end else if (clock_en) begin
            code_ff <= code_nx;
            gap_ff <= frame_hit ? 4'h0 : gap_ff + 4'h1;
            low_ff <= rx_lock ? 5'h00 : low_ff + {4'h0, low_ff != 5'h1F};
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    marker_pair_a: assert property ($past(rst_n) && $past(clock_en) |->
        tx_word[POS_MARK_UP] && !tx_word[POS_MARK_LO])
        else $error("clock marker pair wrong");
    mode_select_a: assert property (clock_en |=>
        mode_active == $past(sel_mode)) else $error("mode not selected");
    plain_payload_a: assert property ($past(clock_en) &&
        $past(mode_active) == MODE_FIRST_GEN &&
        mode_active == MODE_FIRST_GEN && !$past(color_18bit) |->
        pay == (tx_word[POS_BAL] ? ~$past(tx_pixel.rgb) : $past(tx_pixel.rgb)))
        else $error("first generation payload wrong");
    code_frame_a: assert property (gap_ff < 4'hA)
        else $error("no control code frame in time");
    valid_lock_a: assert property (rx_word_valid |-> rx_lock)
        else $error("valid word while unlocked");
    err_lock_a: assert property (rx_word_err |-> $past(rx_lock))
        else $error("word error while unlocked");
    lock_time_a: assert property ($rose(rx_lock) |->
        low_ff >= LOCK_GOOD_WORDS) else $error("lock came too soon");
    pixel_hold_a: assert property ($changed(rx_pixel) |->
        rx_word_valid) else $error("pixel changed without valid word");
    stall_hold_a: assert property ($past(rst_n) && !$past(clock_en) |->
        $stable(tx_word) && $stable(rx_lock)) else $error("state moved in stall");
    cover property ($rose(rx_lock));
    cover property (rx_word_err);
    cover property (mode_active == MODE_FIRST_GEN && rx_word_valid);
endmodule
bind vslc_link_core vslc_link_checker u_chk (
    .clock(clock), .clock_en(clock_en), .rst_n(rst_n),
    .cfg_mode_pin(cfg_mode_pin), .cfg_mode_reg(cfg_mode_reg),
    .cfg_use_reg(cfg_use_reg), .color_18bit(color_18bit),
    .mode_active(mode_active), .tx_pixel(tx_pixel), .tx_word(tx_word),
    .rx_pixel(rx_pixel), .rx_word_valid(rx_word_valid),
    .rx_word_err(rx_word_err), .rx_lock(rx_lock)
);

// [vslc_link_core.sv]
// Pixel framing and coding core: coder toward the lane, decoder from it.
// Assumes one coded word per pixel clock on each lane direction; the
// received lane may arrive at any bit rotation.
//
// Functional notes
// - 24 colour bits plus three controls per pixel
// - Upper marker high, lower marker low, every word
// - Payload carries scrambled colour, raw in mode 11
// - Balance bit says payload sent inverted or not
// - Integrity bit validates stream, carries control code
// - Coder makes both codings; decoder undoes them unaided
// - 24-bit colour: controls only via integrity bit
// - 18-bit colour: controls may ride as data bits
// - Mode 00/01 normal, filter off/on; 10, 11 compat
// - Mode taken from pins or configuration register
// - Filter on: two transitions/130 (frame sync one), pulses under 3 dropped, unless controls ride as data bits
// - Filter off: two transitions/130 (frame sync one) unless controls ride as data bits, any pulse width
// - Filter suppresses control glitches before coding, unless controls ride as data bits
// - Decoder locks without reference clock, any data
// - Decoder locks without training or sync words
// - Decoder aligns, validates, outputs parallel video
`timescale 1ns/100ps
module vslc_link_core import vslc_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic clock_en,
    input wire logic rst_n,
    // Configuration
    input wire logic [1:0] cfg_mode_pin,
    input wire logic [1:0] cfg_mode_reg,
    input wire logic cfg_use_reg,
    input wire logic color_18bit,
    input wire logic ctrl_in_data,
    output logic [1:0] mode_active,
    // Parallel video in
    input wire vslc_pixel_t tx_pixel,
    input wire logic [2:0] tx_gp,
    // Lane out
    output logic [WORD_W-1:0] tx_word,
    // Lane in
    input wire logic [WORD_W-1:0] rx_word,
    // Parallel video out
    output vslc_pixel_t rx_pixel,
    output logic [2:0] rx_gp,
    output logic rx_word_valid,
    output logic rx_word_err,
    output logic rx_lock
);
    localparam logic [LOCK_CNT_W-1:0] GOOD_LAST =
        LOCK_CNT_W'(LOCK_GOOD_WORDS - 1);
    localparam logic [LOCK_CNT_W-1:0] BAD_LAST =
        LOCK_CNT_W'(LOCK_BAD_WORDS - 1);

    // Self-synchronising scrambler feedback, shared by both directions
    function automatic logic [PAY_W-1:0] scr_key(input logic [PAY_W-1:0] s);
        return {s[22:0], s[23]} ^ {s[4:0], s[23:5]};
    endfunction

    function automatic logic [4:0] ones(input logic [PAY_W-1:0] v);
        logic [4:0] n;
        n = 5'h0;
        for (int i = 0; i < PAY_W; i++) n = n + {4'h0, v[i]};
        return n;
    endfunction

    // Mode selection
    wire logic [1:0] mode_sel = cfg_use_reg ? cfg_mode_reg
                                            : cfg_mode_pin;
    wire logic filt_en = (mode_sel == MODE_NORM_FILT);
    wire logic limit_en = !mode_sel[1];
    wire logic scr_en = (mode_sel != MODE_FIRST_GEN);
    wire logic as_data = color_18bit && ctrl_in_data;

    // Transmit control filtering
    logic pv_f;
    logic ls_f;
    logic fs_f;

    vslc_ctrl_filter #(.MAX_TRANS(2)) u_filt_pv (
        .clock(clock),
        .clock_en(clock_en),
        .rst_n(rst_n),
        .glitch_en(filt_en),
        .limit_en(limit_en),
        .sig_in(tx_pixel.pixel_valid),
        .sig_out(pv_f)
    );

    vslc_ctrl_filter #(.MAX_TRANS(2)) u_filt_ls (
        .clock(clock),
        .clock_en(clock_en),
        .rst_n(rst_n),
        .glitch_en(filt_en),
        .limit_en(limit_en),
        .sig_in(tx_pixel.line_sync),
        .sig_out(ls_f)
    );

    // Frame sync is kept slow by the host; the limiter only backs it up
    vslc_ctrl_filter #(.MAX_TRANS(1)) u_filt_fs (
        .clock(clock),
        .clock_en(clock_en),
        .rst_n(rst_n),
        .glitch_en(filt_en),
        .limit_en(limit_en),
        .sig_in(tx_pixel.frame_sync),
        .sig_out(fs_f)
    );

    // Transmit coding
    logic [PAY_W-1:0] tx_prev_ff;
    logic signed [DISP_W-1:0] run_disp_ff;
    logic [2:0] tx_slot_ff;
    logic [2:0] tx_snap_ff;
    logic [WORD_W-1:0] tx_word_ff;
    logic [1:0] mode_ff;

    wire logic [PAY_W-1:0] tx_raw = as_data
        ? {tx_pixel.pixel_valid, tx_pixel.line_sync, tx_pixel.frame_sync,
           tx_gp, tx_pixel.rgb[17:0]}
        : tx_pixel.rgb;
    wire logic [PAY_W-1:0] tx_scr = scr_en ? (tx_raw ^ scr_key(tx_prev_ff))
                                           : tx_raw;
    wire logic signed [5:0] tx_d =
        $signed({1'b0, ones(tx_scr)}) - DISP_MID;
    wire logic signed [DISP_W-1:0] tx_dw = DISP_W'(tx_d);
    // Invert when the word would push the running bias further away
    wire logic tx_inv = ((run_disp_ff > 0) && (tx_d > 0)) ||
                        ((run_disp_ff < 0) && (tx_d < 0));
    wire logic [PAY_W-1:0] tx_bal = tx_inv ? ~tx_scr : tx_scr;
    wire logic [3:0] tx_tail = {tx_snap_ff, ^tx_snap_ff};
    wire logic tx_code = tx_slot_ff[2] ? tx_tail[3 - tx_slot_ff[1:0]]
                                       : CODE_HDR[3 - tx_slot_ff[1:0]];
    wire logic tx_int = tx_code ^ (^tx_bal) ^ tx_inv;
    wire logic [WORD_W-1:0] tx_next =
        {1'b1, 1'b0, tx_inv, tx_int, tx_bal};

    assign tx_word = tx_word_ff;
    assign mode_active = mode_ff;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_prev_ff <= '0;
            run_disp_ff <= '0;
            tx_slot_ff <= 3'h0;
            tx_snap_ff <= 3'h0;
            tx_word_ff <= '0;
            mode_ff <= MODE_NORM_NOFILT;
        end else if (clock_en) begin
            tx_prev_ff <= tx_scr;
            run_disp_ff <= tx_inv ? run_disp_ff - tx_dw
                                  : run_disp_ff + tx_dw;
            tx_slot_ff <= tx_slot_ff + 3'h1;
            if (tx_slot_ff == 3'h3) tx_snap_ff <= {pv_f, ls_f, fs_f};
            tx_word_ff <= tx_next;
            mode_ff <= mode_sel;
        end
    end

    // Receive alignment: any rotation is reachable from two words
    logic [WORD_W-1:0] rx_prev_ff;
    logic [OFF_W-1:0] off_ff;
    vslc_rx_state_t state_ff;
    vslc_rx_state_t nxt_state;
    logic [LOCK_CNT_W-1:0] cnt_ff;

    wire logic [2*WORD_W-1:0] rx_pair = {rx_word, rx_prev_ff};
    wire logic [2*WORD_W-1:0] rx_shift = rx_pair >> off_ff;
    wire logic [WORD_W-1:0] rx_al = rx_shift[WORD_W-1:0];
    wire logic mk_ok = rx_al[POS_MARK_UP] && !rx_al[POS_MARK_LO];
    wire logic locked = (state_ff == RX_LOCKED);
    wire logic slip = !mk_ok && (state_ff != RX_LOCKED);
    wire logic [OFF_W-1:0] off_next =
        (off_ff == OFF_MAX) ? '0 : off_ff + 5'h1;

    // Lock needs nothing but the marker pair in live data
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            RX_HUNT: begin
                if (mk_ok) nxt_state = RX_VERIFY;
            end
            RX_VERIFY: begin
                if (!mk_ok) nxt_state = RX_HUNT;
                else if (cnt_ff == GOOD_LAST) nxt_state = RX_LOCKED;
            end
            RX_LOCKED: begin
                if (!mk_ok && cnt_ff == BAD_LAST) nxt_state = RX_HUNT;
            end
            default: nxt_state = RX_HUNT;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_prev_ff <= '0;
            off_ff <= '0;
            state_ff <= RX_HUNT;
            cnt_ff <= '0;
        end else if (clock_en) begin
            rx_prev_ff <= rx_word;
            state_ff <= nxt_state;
            if (slip) off_ff <= off_next;
            if (nxt_state != state_ff) cnt_ff <= '0;
            else if (locked) cnt_ff <= mk_ok ? '0 : cnt_ff + 5'h1;
            else if (mk_ok) cnt_ff <= cnt_ff + 5'h1;
        end
    end

    // Receive decoding
    logic [PAY_W-1:0] rx_sprev_ff;
    logic [CODE_LEN-1:0] code_sr_ff;
    logic [3:0] gap_ff;
    logic [2:0] ctrl_ff;
    vslc_pixel_t rx_pixel_ff;
    logic [2:0] rx_gp_ff;
    logic valid_ff;
    logic err_ff;

    wire logic [PAY_W-1:0] rx_s =
        rx_al[PAY_W-1:0] ^ {PAY_W{rx_al[POS_BAL]}};
    wire logic [PAY_W-1:0] rx_d = scr_en ? (rx_s ^ scr_key(rx_sprev_ff))
                                         : rx_s;
    wire logic rx_code = rx_al[POS_INT] ^ (^rx_al[PAY_W-1:0]) ^
                         rx_al[POS_BAL];
    wire logic [CODE_LEN-1:0] code_nxt = {code_sr_ff[CODE_LEN-2:0], rx_code};
    wire logic frame_ok = (code_nxt[7:4] == CODE_HDR) &&
                          (code_nxt[0] == ^code_nxt[3:1]);
    wire logic good = locked && mk_ok;
    // A missing code frame or broken marker pair marks the stream bad
    wire logic gap_bad = good && !frame_ok && (gap_ff == CODE_GAP_MAX);
    wire logic word_bad = (locked && !mk_ok) || gap_bad;

    assign rx_pixel = rx_pixel_ff;
    assign rx_gp = rx_gp_ff;
    assign rx_word_valid = valid_ff;
    assign rx_word_err = err_ff;
    assign rx_lock = locked;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_sprev_ff <= '0;
            code_sr_ff <= '0;
            gap_ff <= 4'h0;
            ctrl_ff <= 3'h0;
            rx_pixel_ff <= '0;
            rx_gp_ff <= 3'h0;
            valid_ff <= 1'b0;
            err_ff <= 1'b0;
        end else if (clock_en) begin
            valid_ff <= good && !gap_bad;
            err_ff <= word_bad;
            if (mk_ok) begin
                rx_sprev_ff <= rx_s;
                code_sr_ff <= code_nxt;
            end
            if (!good || frame_ok) gap_ff <= 4'h0;
            else if (gap_ff != CODE_GAP_MAX) gap_ff <= gap_ff + 4'h1;
            if (good && frame_ok) ctrl_ff <= code_nxt[3:1];
            if (good && !gap_bad) begin
                if (as_data) begin
                    rx_pixel_ff.rgb <= {6'h00, rx_d[17:0]};
                    rx_pixel_ff.pixel_valid <= rx_d[23];
                    rx_pixel_ff.line_sync <= rx_d[22];
                    rx_pixel_ff.frame_sync <= rx_d[21];
                    rx_gp_ff <= rx_d[20:18];
                end else begin
                    rx_pixel_ff.rgb <= rx_d;
                    rx_pixel_ff.pixel_valid <= frame_ok ? code_nxt[3]
                                                        : ctrl_ff[2];
                    rx_pixel_ff.line_sync <= frame_ok ? code_nxt[2]
                                                      : ctrl_ff[1];
                    rx_pixel_ff.frame_sync <= frame_ok ? code_nxt[1]
                                                       : ctrl_ff[0];
                    rx_gp_ff <= 3'h0;
                end
            end
        end
    end
endmodule

// [vslc_link_core_test.sv]
// Self-checking bench: the core's coder loops back to its decoder.
// Assumes the lane model between them; inputs move at the falling edge.
`timescale 1ns/100ps
module vslc_link_core_test import vslc_pkg::*;;
    typedef struct packed {
        logic [1:0] mode;
        logic c18;
        logic [23:0] rgb;
        logic [2:0] gp;
    } vslc_row_t;
    vslc_row_t rows [5] = '{'{2'h0, 1'h0, 24'h000000, 3'h0},
        '{2'h1, 1'h0, 24'hFFFFFF, 3'h0}, '{2'h2, 1'h0, 24'h5A0F3C, 3'h0},
        '{2'h3, 1'h0, 24'h123456, 3'h0}, '{2'h0, 1'h1, 24'hC1B2A3, 3'h5}};
    logic clock, rst_n, clock_en, cfg_use_reg, color_18bit, ctrl_in_data;
    logic corrupt, rx_word_valid, rx_word_err, rx_lock;
    logic [1:0] cfg_mode_pin, cfg_mode_reg, mode_active;
    logic [2:0] tx_gp, rx_gp;
    logic [4:0] rot;
    logic [23:0] m;
    logic [27:0] tx_word, rx_word, w;
    vslc_pixel_t tx_pixel, rx_pixel;
    int fail_count = 0;
    int checks = 0;
    int cyc_count = 0;
    int n, run, worst;
    vslc_link_core u_dut (.clock(clock), .clock_en(clock_en), .rst_n(rst_n),
        .cfg_mode_pin(cfg_mode_pin), .cfg_mode_reg(cfg_mode_reg),
        .cfg_use_reg(cfg_use_reg), .color_18bit(color_18bit),
        .ctrl_in_data(ctrl_in_data), .mode_active(mode_active),
        .tx_pixel(tx_pixel), .tx_gp(tx_gp), .tx_word(tx_word),
        .rx_word(rx_word), .rx_pixel(rx_pixel), .rx_gp(rx_gp),
        .rx_word_valid(rx_word_valid), .rx_word_err(rx_word_err),
        .rx_lock(rx_lock));
    vslc_lane_model u_lane (.clock(clock), .clock_en(clock_en), .rot(rot),
        .corrupt(corrupt), .word_in(tx_word), .word_out(rx_word));
    task automatic complete_run();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [27:0] exp,
        input logic [27:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clock);
    endtask
    task automatic wait_lock();
        int i;
        i = 0;
        while (rx_lock !== 1'b1 && i < 400) begin
            cyc(1);
            i++;
        end
        check("rx_lock", 1, rx_lock);
    endtask
    // Counts line sync edges seen at the decoder output
    task automatic count_ls(input int k, output int t);
        logic last;
        t = 0;
        last = rx_pixel.line_sync;
        repeat (k) begin
            cyc(1);
            if (rx_pixel.line_sync !== last) t++;
            last = rx_pixel.line_sync;
        end
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc_count++;
        if (cyc_count == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        rst_n = 1'b0;
        clock_en = 1'b1;
        {cfg_use_reg, color_18bit, ctrl_in_data, corrupt} = 4'h0;
        {cfg_mode_pin, cfg_mode_reg, tx_gp, rot} = 12'h000;
        tx_pixel = '0;
        cyc(16);
        check("mode_active", 0, mode_active);
        check("rx_lock", 0, rx_lock);
        rst_n = 1'b1;
        wait_lock();
        $display("test reset and lock done");
        foreach (rows[i]) begin
            cfg_mode_pin = rows[i].mode;
            {color_18bit, ctrl_in_data} = {2{rows[i].c18}};
            tx_pixel.rgb = rows[i].rgb;
            tx_gp = rows[i].gp;
            m = rows[i].c18 ? 24'h03FFFF : 24'hFFFFFF;
            cyc(10);
            check("mode_active", rows[i].mode, mode_active);
            check("rgb", rows[i].rgb & m, rx_pixel.rgb & m);
            check("gp", rows[i].gp, rx_gp);
        end
        {color_18bit, ctrl_in_data} = 2'h0;
        $display("test rows done");
        {cfg_use_reg, cfg_mode_reg} = {1'b1, MODE_SECOND_GEN};
        cyc(2);
        check("mode_active", MODE_SECOND_GEN, mode_active);
        cfg_use_reg = 1'b0;
        cfg_mode_pin = MODE_FIRST_GEN;
        tx_pixel.rgb = 24'hFFFFFF;
        cyc(2);
        run = 0;
        worst = 0;
        repeat (32) begin
            cyc(1);
            run += $countones(tx_word[23:0]) - 12;
            worst = run > worst ? run : (-run > worst ? -run : worst);
        end
        check("disparity", 1, worst <= 24);
        w = tx_word;
        clock_en = 1'b0;
        cyc(3);
        check("stalled word", w, tx_word);
        clock_en = 1'b1;
        $display("test balance and stall done");
        cfg_mode_pin = MODE_NORM_FILT;
        cyc(140);
        tx_pixel.line_sync = 1'b1;
        cyc(2);
        tx_pixel.line_sync = 1'b0;
        count_ls(60, n);
        check("glitch edges", 0, n);
        // Count from the start, the rising edge may cross before the fall
        fork
            begin
                tx_pixel.line_sync = 1'b1;
                cyc(10);
                tx_pixel.line_sync = 1'b0;
            end
            count_ls(60, n);
        join
        check("pulse edges", 2, n);
        cfg_mode_pin = MODE_NORM_NOFILT;
        cyc(140);
        fork
            repeat (3) begin
                tx_pixel.line_sync = 1'b1;
                cyc(10);
                tx_pixel.line_sync = 1'b0;
                cyc(10);
            end
            count_ls(100, n);
        join
        check("limited edges", 2, n);
        {tx_pixel.pixel_valid, tx_pixel.frame_sync} = 2'h3;
        cyc(30);
        check("pixel_valid", 1, rx_pixel.pixel_valid);
        check("frame_sync", 1, rx_pixel.frame_sync);
        check("word_valid", 1, rx_word_valid);
        $display("test control filter done");
        cyc(300);
        n = 0;
        corrupt = 1'b1;
        repeat (6) begin
            cyc(1);
            n += rx_word_err === 1'b1;
        end
        corrupt = 1'b0;
        check("lock after bad words", 0, rx_lock);
        check("word errors", 1, n > 0);
        rot = 5'h0D;
        wait_lock();
        tx_pixel.rgb = 24'h3C96E1;
        cyc(10);
        check("rgb slipped", 24'h3C96E1, rx_pixel.rgb);
        $display("test error and slip done");
        complete_run();
    end
endmodule

// [vslc_pkg.sv]
// Shared constants and types for the video serial link coding core.
// Assumes one pixel clock domain; the lane carries one coded word per cycle.
package vslc_pkg;
    // Coded word layout
    localparam int WORD_W = 28;
    localparam int PAY_W = 24;
    localparam int POS_MARK_UP = 27;
    localparam int POS_MARK_LO = 26;
    localparam int POS_BAL = 25;
    localparam int POS_INT = 24;
    localparam int OFF_W = 5;
    localparam logic [4:0] OFF_MAX = 5'h1B;
    // Normal and compatibility modes
    localparam logic [1:0] MODE_NORM_NOFILT = 2'h0;
    localparam logic [1:0] MODE_NORM_FILT = 2'h1;
    localparam logic [1:0] MODE_SECOND_GEN = 2'h2;
    localparam logic [1:0] MODE_FIRST_GEN = 2'h3;
    // Video control timing, in pixel clocks
    localparam int CTRL_WIN_CYC = 130;
    localparam int CTRL_MIN_PULSE = 3;
    localparam int CTRL_CNT_W = 8;
    // Control code frame carried one bit per word on the integrity bit
    localparam logic [3:0] CODE_HDR = 4'hE;
    localparam int CODE_LEN = 8;
    localparam logic [3:0] CODE_GAP_MAX = 4'h8;
    // Lock acquisition and running disparity
    localparam int LOCK_GOOD_WORDS = 16;
    localparam int LOCK_BAD_WORDS = 4;
    localparam int LOCK_CNT_W = 5;
    localparam int DISP_W = 8;
    localparam logic signed [5:0] DISP_MID = 6'sh0C;

    typedef struct packed {
        logic [23:0] rgb;
        logic pixel_valid;
        logic line_sync;
        logic frame_sync;
    } vslc_pixel_t;

    typedef enum logic [2:0] {
        RX_HUNT = 3'h1,
        RX_VERIFY = 3'h2,
        RX_LOCKED = 3'h4
    } vslc_rx_state_t;
endpackage
